// *** inc/sdrpo_pkg.sv ***
package sdrpo_pkg;
  // Command word layout
  localparam int          CMD_W        = 32;
  localparam int          WRITE_BIT    = 31;
  localparam int          CODE_HI      = 30;
  localparam int          CODE_LO      = 24;
  localparam logic [6:0]  CODE_DIAG_HI = 7'h05;
  localparam logic [6:0]  CODE_PHASE_LO = 7'h06;
  // Diagnostic flags: six per channel, channel 4 on top
  localparam int          DIAG_W       = 24;
  localparam int          DIAG_PER_CH  = 6;
  localparam logic [23:0] DIAG_RESET   = 24'h000000;
  // Phase offsets: four five-bit fields, channel 0 on top
  localparam int          OFFS_W       = 5;
  localparam int          OFFS_ALL_W   = 20;
  localparam logic [19:0] OFFS_RESET   = 20'h00000;
  localparam logic [3:0]  RSP_PAD      = 4'h0;
  // Period generator
  localparam int          NUM_CH       = 4;
  localparam int          SLOTS        = 32;
  localparam logic [13:0] N_RESET      = 14'h0271;
  localparam logic [1:0]  M_RESET      = 2'h0;

  typedef enum logic [0:0] {
    SDRPO_WAIT_SYNC = 1'b0,
    SDRPO_ALIGNED   = 1'b1
  } sdrpo_sync_type;

  // Samples per one thirty-second of the period, from the samples-per-period code
  function automatic logic [4:0] sdrpo_slot_len(input logic [1:0] m_code);
    unique case (m_code)
      2'h0: sdrpo_slot_len = 5'h01;
      2'h1: sdrpo_slot_len = 5'h02;
      2'h2: sdrpo_slot_len = 5'h04;
      2'h3: sdrpo_slot_len = 5'h04;
    endcase
  endfunction : sdrpo_slot_len
endpackage : sdrpo_pkg

// *** logic/sdrpo_core.sv ***
`timescale 1ns/10ps
module sdrpo_core
  import sdrpo_pkg::*;
#(
  parameter int N_W = 14
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Command word in, response word out
  input  wire logic                  cmd_valid,
  input  wire logic [CMD_W-1:0]      cmd_word,
  output      logic                  rsp_valid,
  output      logic [CMD_W-1:0]      rsp_word,
  // Fault and test-status levels from the detectors, channels 4 to 7 (bit 0 is channel 4)
  input  wire logic [NUM_CH-1:0]     ground_short_fault,
  input  wire logic [NUM_CH-1:0]     gate_off_test_done,
  input  wire logic [NUM_CH-1:0]     battery_short_fault,
  input  wire logic [NUM_CH-1:0]     battery_short_test_done,
  input  wire logic [NUM_CH-1:0]     open_load_gate_low_fault,
  input  wire logic [NUM_CH-1:0]     open_load_gate_high_fault,
  // Period setup from the period-set message
  input  wire logic [N_W-1:0]        sample_divider,
  input  wire logic [1:0]            samples_code,
  // Phase alignment
  input  wire logic                  phase_sync,
  output      logic                  aligned,
  output      logic                  period_start,
  output      logic [NUM_CH-1:0]     chan_start,
  output      logic [OFFS_ALL_W-1:0] channel_phase_delay
);

  if (N_W < 10 || N_W > 16) begin : g_bad_width
    $error("sdrpo_core: N_W must be 10 to 16");
  end

  // Diagnostic flag group
  logic [DIAG_W-1:0] diag_flags;
  logic [DIAG_W-1:0] next_diag_flags;

  // Flags mirror the detectors; no command touches them
  always_comb begin
    next_diag_flags = diag_flags;
    for (int k = 0; k < NUM_CH; k++) begin
      next_diag_flags[DIAG_W-1-DIAG_PER_CH*k]     = ground_short_fault[k];
      next_diag_flags[DIAG_W-2-DIAG_PER_CH*k]     = gate_off_test_done[k];
      next_diag_flags[DIAG_W-3-DIAG_PER_CH*k]     = battery_short_fault[k];
      next_diag_flags[DIAG_W-4-DIAG_PER_CH*k]     = battery_short_test_done[k];
      next_diag_flags[DIAG_W-5-DIAG_PER_CH*k]     = open_load_gate_low_fault[k];
      next_diag_flags[DIAG_W-6-DIAG_PER_CH*k]     = open_load_gate_high_fault[k];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_flags <= DIAG_RESET;
    end else begin
      diag_flags <= next_diag_flags;
    end
  end

  // Command group
  logic [6:0]            cmd_code;
  logic                  next_rsp_valid;
  logic [CMD_W-1:0]      next_rsp_word;
  logic [OFFS_ALL_W-1:0] next_phase_delay;

  assign cmd_code = cmd_word[CODE_HI:CODE_LO];

  always_comb begin
    next_rsp_valid   = cmd_valid;
    next_rsp_word    = rsp_word;
    next_phase_delay = channel_phase_delay;
    if (cmd_valid) begin
      // Unknown codes still answer, with the code echoed and zero data
      next_rsp_word = {1'b0, cmd_code, 24'h000000};
      unique case (cmd_code)
        CODE_DIAG_HI: begin
          // Write flag ignored on purpose
          next_rsp_word[DIAG_W-1:0] = diag_flags;
        end
        CODE_PHASE_LO: begin
          if (cmd_word[WRITE_BIT]) begin
            // Bits 23:20 above the offsets are dropped here
            next_phase_delay = cmd_word[OFFS_ALL_W-1:0];
          end
          next_rsp_word[23:OFFS_ALL_W]   = RSP_PAD;
          next_rsp_word[OFFS_ALL_W-1:0]  = next_phase_delay;
        end
        default: begin
          next_rsp_word = {1'b0, cmd_code, 24'h000000};
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid           <= 1'b0;
      rsp_word            <= '0;
      channel_phase_delay <= OFFS_RESET;
    end else begin
      rsp_valid           <= next_rsp_valid;
      rsp_word            <= next_rsp_word;
      channel_phase_delay <= next_phase_delay;
    end
  end

  // Timing group
  sdrpo_sync_type    sync_state;
  sdrpo_sync_type    next_sync_state;
  logic [N_W-1:0]    n_count;
  logic [N_W-1:0]    next_n_count;
  logic [4:0]        sub_count;
  logic [4:0]        next_sub_count;
  logic [4:0]        slot;
  logic [4:0]        next_slot;
  logic              next_period_start;
  logic [NUM_CH-1:0] next_chan_start;
  logic              sample_tick;
  logic              slot_edge;
  logic [4:0]        slot_len;

  assign slot_len    = sdrpo_slot_len(samples_code);
  // A divider of zero behaves as one
  assign sample_tick = ({1'b0, n_count} + 1'b1) >= {1'b0, sample_divider};
  assign slot_edge   = sample_tick && (sub_count + 5'h01 >= slot_len);
  assign aligned     = (sync_state == SDRPO_ALIGNED);

  always_comb begin
    next_sync_state   = sync_state;
    next_n_count      = n_count;
    next_sub_count    = sub_count;
    next_slot         = slot;
    next_period_start = 1'b0;
    next_chan_start   = '0;
    if (phase_sync) begin
      // Restart the period so every channel shares one reference
      next_sync_state   = SDRPO_ALIGNED;
      next_n_count      = '0;
      next_sub_count    = 5'h00;
      next_slot         = 5'h00;
      next_period_start = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        next_chan_start[c] = (channel_phase_delay[OFFS_ALL_W-1-OFFS_W*c -: OFFS_W] == 5'h00);
      end
    end else if (sync_state == SDRPO_ALIGNED) begin
      next_n_count = sample_tick ? '0 : n_count + 1'b1;
      if (sample_tick) begin
        next_sub_count = slot_edge ? 5'h00 : sub_count + 5'h01;
      end
      if (slot_edge) begin
        next_slot         = slot + 5'h01;
        next_period_start = (slot == 5'(SLOTS - 1));
        for (int c = 0; c < NUM_CH; c++) begin
          next_chan_start[c] = (channel_phase_delay[OFFS_ALL_W-1-OFFS_W*c -: OFFS_W] == next_slot);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_state   <= SDRPO_WAIT_SYNC;
      n_count      <= '0;
      sub_count    <= 5'h00;
      slot         <= 5'h00;
      period_start <= 1'b0;
      chan_start   <= '0;
    end else begin
      sync_state   <= next_sync_state;
      n_count      <= next_n_count;
      sub_count    <= next_sub_count;
      slot         <= next_slot;
      period_start <= next_period_start;
      chan_start   <= next_chan_start;
    end
  end

  // Checks
  a_diag_echo_code: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == CODE_DIAG_HI |=> rsp_valid && rsp_word[31:24] == {1'b0, CODE_DIAG_HI})
    else $error("diagnostic response header wrong");
  a_diag_write_inert: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == CODE_DIAG_HI |=> channel_phase_delay == $past(channel_phase_delay))
    else $error("diagnostic command changed offsets");
  // Flags are a registered copy, so the answer shows the detectors two edges back
  a_diag_flag_layout: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == CODE_DIAG_HI |=>
      rsp_word[23:18] == $past({ground_short_fault[0], gate_off_test_done[0], battery_short_fault[0],
                                battery_short_test_done[0], open_load_gate_low_fault[0],
                                open_load_gate_high_fault[0]}, 2)
      && rsp_word[17] == $past(ground_short_fault[1], 2) && rsp_word[11] == $past(ground_short_fault[2], 2)
      && rsp_word[5] == $past(ground_short_fault[3], 2) && rsp_word[0] == $past(open_load_gate_high_fault[3], 2))
    else $error("diagnostic flag position wrong");
  a_phase_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == CODE_PHASE_LO && cmd_word[WRITE_BIT] |=> channel_phase_delay == $past(cmd_word[19:0]))
    else $error("offset write not stored");
  a_phase_read_only: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == CODE_PHASE_LO && !cmd_word[WRITE_BIT] |=> $stable(channel_phase_delay))
    else $error("offset read changed offsets");
  a_phase_resp_body: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == CODE_PHASE_LO |=> rsp_word[31:20] == {1'b0, CODE_PHASE_LO, 4'h0}
      && rsp_word[19:0] == channel_phase_delay)
    else $error("offset response wrong");
  a_sync_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    phase_sync |=> period_start && aligned && slot == 5'h00)
    else $error("phase sync did not restart period");
  a_no_start_unaligned: assert property (@(posedge mclk) disable iff (!rst_n)
    !aligned |-> chan_start == '0 && !period_start)
    else $error("channel start before alignment");
  a_zero_offset_start: assert property (@(posedge mclk) disable iff (!rst_n)
    period_start && $past(channel_phase_delay[19:15]) == 5'h00 |-> chan_start[0])
    else $error("zero-offset channel missed period start");

endmodule : sdrpo_core

// *** verification/sdrpo_host.sv ***
`timescale 1ns/10ps
// Host master model: whole command words, one sync pulse per alignment
module sdrpo_host
  import sdrpo_pkg::*;
(
  // Clock
  input  wire logic             mclk,
  // Command port
  output      logic             cmd_valid,
  output      logic [CMD_W-1:0] cmd_word,
  input  wire logic             rsp_valid,
  input  wire logic [CMD_W-1:0] rsp_word,
  // Phase alignment
  output      logic             phase_sync
);
  initial begin
    cmd_valid  = 1'b0;
    cmd_word   = 32'h0;
    phase_sync = 1'b0;
  end
  task automatic xfer(input logic [CMD_W-1:0] w, output logic ok, output logic [CMD_W-1:0] r);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_word  <= w;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // Idle word is inverted so a stale copy cannot pass for a new command
    cmd_word  <= ~w;
    #1;
    ok = rsp_valid;
    r  = rsp_word;
  endtask : xfer
  task automatic sync_pulse();
    @(posedge mclk);
    phase_sync <= 1'b1;
    @(posedge mclk);
    phase_sync <= 1'b0;
    #1;
  endtask : sync_pulse
endmodule : sdrpo_host

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import sdrpo_pkg::*;
;
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  cmd_valid, rsp_valid, phase_sync, aligned, period_start;
  logic [CMD_W-1:0]      cmd_word, rsp_word;
  logic [5:0][3:0]       fl = '0;
  logic [13:0]           sample_divider = 14'h0002;
  logic [1:0]            samples_code = 2'h0;
  logic [NUM_CH-1:0]     chan_start;
  logic [OFFS_ALL_W-1:0] channel_phase_delay;
  int                    err_total = 0;
  int                    cmp_count = 0;

  always #4 mclk = ~mclk;

  sdrpo_host host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rsp_valid(rsp_valid),
                   .rsp_word(rsp_word), .phase_sync(phase_sync));
  sdrpo_core uut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .ground_short_fault(fl[0]), .gate_off_test_done(fl[1]),
    .battery_short_fault(fl[2]), .battery_short_test_done(fl[3]), .open_load_gate_low_fault(fl[4]),
    .open_load_gate_high_fault(fl[5]), .sample_divider(sample_divider), .samples_code(samples_code),
    .phase_sync(phase_sync), .aligned(aligned), .period_start(period_start), .chan_start(chan_start),
    .channel_phase_delay(channel_phase_delay));

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Six flags per channel, channel 4 in the top group
  function automatic logic [23:0] diag_exp(input logic [5:0][3:0] f);
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 6; j++)
        diag_exp[23-6*k-j] = f[j][k];
  endfunction : diag_exp

  task automatic xfer_chk(input logic [31:0] w, input logic [31:0] e);
    logic        ok;
    logic [31:0] r;
    host.xfer(w, ok, r);
    check("rsp_valid", ok, 32'h1);
    check("rsp_word", r, e);
  endtask : xfer_chk

  task automatic phase_run(input logic [13:0] d, input logic [1:0] code, input logic [19:0] offs);
    int         p;
    logic [4:0] e;
    p = d * ((code == 2'h0) ? 1 : (code == 2'h1) ? 2 : 4);
    @(posedge mclk);
    sample_divider <= d;
    samples_code   <= code;
    xfer_chk({1'b1, CODE_PHASE_LO, 4'h0, offs}, {1'b0, CODE_PHASE_LO, 4'h0, offs});
    host.sync_pulse();
    check("aligned", aligned, 32'h1);
    for (int i = 0; i <= 32 * p; i++) begin
      e[4] = (i % (32 * p)) == 0;
      for (int c = 0; c < 4; c++)
        e[c] = (i % (32 * p)) == offs[19-5*c -: 5] * p;
      check("pulses", {period_start, chan_start}, e);
      @(posedge mclk);
      #1;
    end
  endtask : phase_run

  initial begin
    logic [31:0]     w;
    logic [19:0]     cur;
    logic [5:0][3:0] f;
    void'($urandom(32'hC8B41354));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    // Nothing may pulse until the host has aligned the timing
    repeat (8) begin
      @(posedge mclk);
      #1;
      check("idle", {aligned, period_start, chan_start}, 32'h0);
    end
    xfer_chk(32'h0500_0000, 32'h0500_0000);
    xfer_chk(32'h0600_0000, 32'h0600_0000);
    for (int i = 0; i < 24; i++) begin
      f = (i == 0) ? '1 : 24'($urandom);
      w = $urandom;
      w[30:24] = CODE_DIAG_HI;
      @(posedge mclk);
      fl <= f;
      xfer_chk(w, {1'b0, CODE_DIAG_HI, diag_exp(f)});
    end
    cur = '0;
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      w[30:24] = CODE_PHASE_LO;
      if (w[31])
        cur = w[19:0];
      xfer_chk(w, {1'b0, CODE_PHASE_LO, 4'h0, cur});
      check("offsets", channel_phase_delay, cur);
    end
    phase_run(14'h0002, 2'h0, {5'h00, 5'h1F, 5'h01, 5'h10});
    // Reset in mid-run must drop the offsets and the alignment
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    xfer_chk(32'h0600_0000, 32'h0600_0000);
    check("realign", aligned, 32'h0);
    for (int c = 1; c < 4; c++)
      phase_run(14'(1 + $urandom % 3), 2'(c), 20'($urandom));
    print_verdict();
  end

  // Longest path is well under 10000 cycles
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule : tb_top
